// >>> lsr_defines.vh
// Purpose: Constants for the line status flag block.
// Assumes: 32-bit APB register access, 40 MHz clock.
// Notes:   Offsets are byte addresses of aligned words.
`ifndef LSR_DEFINES_VH
`define LSR_DEFINES_VH
`define OFS_STATUS      12'h014
`define OFS_CONTROL     12'h004
`define OFS_TXDATA      12'h000
`define OFS_RXDATA      12'h008
`define OFS_TXSTATE     12'h00C
`define BIT_RX_READY    0
`define BIT_FRAME_ERR   3
`define BIT_BREAK       4
`define BIT_HOLD_EMPTY  5
`define BIT_ALL_EMPTY   6
`define CTL_HOLD_IEN    0
`define CTL_FIFO_MODE   1
`define CTL_PARITY_EN   2
`define CTL_DIV_LO      8
`define CTL_DIV_W       16
`define CTL_RESET       32'h00010000
`define OVERSAMPLE      4'hF
`define MID_SAMPLE      4'h7
`define DATA_BITS       4'h8
`endif

// >>> tx_side.v
// Purpose: Transmit holding register, optional FIFO and shift register.
// Assumes: Writes arrive as one-cycle strobes; bit_tick is a one-cycle enable.
// Notes:   Reports occupancy only; the status flags are formed by the top.
`timescale 1ns/100ps
`default_nettype none
module tx_side #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       fifo_mode,
  input  wire       wr_stb,
  input  wire [7:0] wr_data,
  input  wire       bit_tick,
  output reg        txd,
  output wire       hold_empty,
  output wire       shift_busy,
  output wire       move_stb
);
  reg [7:0]    mem [0:DEPTH-1];
  reg [AW-1:0] rd_q;
  reg [AW-1:0] wr_q;
  reg [AW:0]   cnt_q;
  reg [9:0]    sh_q;
  reg [3:0]    bits_q;
  wire         cap;

  // In holding-register mode the storage is one deep.
  assign cap        = fifo_mode ? (cnt_q == DEPTH) : (cnt_q != {(AW+1){1'b0}});
  assign hold_empty = (cnt_q == {(AW+1){1'b0}});
  assign shift_busy = (bits_q != 4'h0);
  assign move_stb   = bit_tick && !shift_busy && !hold_empty;

  // Writes to a full store are dropped, as a real holding register would overwrite nothing.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q   <= {AW{1'b0}};
      wr_q   <= {AW{1'b0}};
      cnt_q  <= {(AW+1){1'b0}};
      sh_q   <= 10'h3FF;
      bits_q <= 4'h0;
      txd    <= 1'b1;
    end else begin
      if (wr_stb && !cap) begin
        mem[wr_q] <= wr_data;
        wr_q      <= wr_q + 1'b1;
      end
      if (move_stb)
        rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + {{AW{1'b0}}, (wr_stb && !cap)} - {{AW{1'b0}}, move_stb};
      if (move_stb) begin
        sh_q   <= {1'b1, mem[rd_q], 1'b0};
        bits_q <= 4'hA;
      end else if (bit_tick && shift_busy) begin
        txd    <= sh_q[0];
        sh_q   <= {1'b1, sh_q[9:1]};
        bits_q <= bits_q - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rx_side.v
// Purpose: Receiver with break detection and framing resynchronisation.
// Assumes: RXD synchronous to clk; os_tick is a 16x oversampling enable.
// Notes:   Emits one character strobe with its error bits.
`timescale 1ns/100ps
`default_nettype none
`include "lsr_defines.vh"
module rx_side (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       os_tick,
  input  wire       parity_en,
  input  wire       rxd,
  output reg        chr_stb,
  output reg  [7:0] chr_data,
  output reg        chr_frame,
  output reg        chr_break
);
  localparam IDLE  = 2'b00;
  localparam START = 2'b01;
  localparam DATA  = 2'b10;
  localparam STOP  = 2'b11;
  reg [1:0]  st_q;
  reg [3:0]  os_q;
  reg [3:0]  bit_q;
  reg [8:0]  sh_q;
  reg        resync_q;
  reg        start_hits_q;
  reg [7:0]  low_q;
  reg        brk_done_q;
  reg        pend_q;
  wire [3:0] nbits;
  wire [7:0] char_time;

  assign nbits     = parity_en ? (`DATA_BITS + 4'h1) : `DATA_BITS;
  // Start, data, parity and stop periods in oversample ticks.
  assign char_time = {nbits + 4'h2, 4'h0};

  // The low-level counter runs alongside the character engine.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_q      <= 8'h00;
      brk_done_q <= 1'b0;
    end else if (rxd) begin
      low_q      <= 8'h00;
      brk_done_q <= 1'b0;
    end else if (chr_stb && chr_break) begin
      // Checked first, so a running counter cannot hide the end of a break.
      brk_done_q <= 1'b1;
    end else if (os_tick && low_q != 8'hFF) begin
      low_q <= low_q + 8'h01;
    end
  end

  // Character engine; a break yields one zero character, however long.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= IDLE; os_q <= 4'h0; bit_q <= 4'h0; sh_q <= 9'h000;
      resync_q <= 1'b0; start_hits_q <= 1'b0; chr_stb <= 1'b0;
      chr_data <= 8'h00; chr_frame <= 1'b0; chr_break <= 1'b0; pend_q <= 1'b0;
    end else begin
      chr_stb <= 1'b0;
      if (os_tick && !rxd && low_q > char_time && !brk_done_q && !chr_stb) begin
        chr_stb   <= 1'b1;
        chr_data  <= 8'h00;
        chr_break <= 1'b1;
        chr_frame <= 1'b1;
        pend_q    <= 1'b0;
        st_q      <= IDLE;
      end else if (pend_q && rxd) begin
        // The line rose before break time: the held zero frame was a real character.
        chr_stb   <= 1'b1;
        chr_data  <= 8'h00;
        chr_frame <= 1'b1;
        chr_break <= 1'b0;
        pend_q    <= 1'b0;
      end else if (os_tick) begin
        case (st_q)
          IDLE: begin
            if (!rxd && !brk_done_q && !pend_q && !chr_stb) begin
              st_q <= START; os_q <= 4'h0; start_hits_q <= 1'b0;
            end
          end
          START: begin
            os_q <= os_q + 4'h1;
            // A resync start must be seen low at two samples
            if (os_q == `MID_SAMPLE || (resync_q && os_q == `MID_SAMPLE + 4'h2)) begin
              if (rxd) begin
                st_q <= IDLE; resync_q <= 1'b0;
              end else if (!resync_q || start_hits_q) begin
                // A resync start is taken two ticks past its middle, so the data
                // counter starts ahead to keep sampling at bit centres.
                st_q <= DATA; os_q <= resync_q ? 4'h2 : 4'h0; bit_q <= 4'h0;
              end else begin
                start_hits_q <= 1'b1;
              end
            end
          end
          DATA: begin
            os_q <= os_q + 4'h1;
            if (os_q == `OVERSAMPLE) begin
              sh_q  <= {rxd, sh_q[8:1]};
              bit_q <= bit_q + 4'h1;
              if (bit_q + 4'h1 == nbits) st_q <= STOP;
            end
          end
          default: begin
            os_q <= os_q + 4'h1;
            if (os_q == `OVERSAMPLE) begin
              resync_q     <= !rxd;
              start_hits_q <= !rxd;  // The low stop is the first start sample
              os_q         <= 4'h8;  // low stop taken as mid of next start
              if (!rxd && (parity_en ? sh_q : {1'b0, sh_q[8:1]}) == 9'h000) begin
                // An all-zero frame may be the front of a break; hold it until
                // the line decides, so a break yields one character only.
                pend_q <= 1'b1;
                st_q   <= IDLE;
              end else begin
                chr_stb   <= 1'b1;
                chr_data  <= parity_en ? sh_q[7:0] : sh_q[8:1];
                chr_frame <= !rxd;
                chr_break <= 1'b0;
                st_q      <= rxd ? IDLE : START;
              end
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> uart_line_status.v
// Purpose: Line status flags of an asynchronous serial port, APB slave.
// Assumes: One 40 MHz clock; RXD synchronous; APB master as published.
// Notes:   Receive FIFO holds character plus frame and break bits.
//
// What this block does
// - All-empty set only when holding, FIFO, shifter empty
// - All-empty clears when any character is held
// - Holding-empty set when holding register/FIFO empty
// - Interrupt while holding-empty and its enable set
// - Holding-empty sets when character moves to shifter
// - Holding-empty clears in the write cycle
// - Break set after low beyond character time
// - Reading status clears break flag
// - FIFO mode reports break at its character
// - One zero character per break
// - Framing error low taken as next start
// - Resync start sampled twice before data
// - Low stop bit flags framing error
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "lsr_defines.vh"
module uart_line_status #(
  parameter RX_DEPTH = 16,
  parameter RX_AW    = 4
) (
  input  wire        MCLK,
  input  wire        RESETN,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        RXD,
  output reg         TXD,
  output reg         TX_IRQ
);
  reg  [31:0]     ctl_q;
  reg  [15:0]     div_q;
  reg             os_tick_q;
  reg  [3:0]      tick16_q;
  reg             bit_tick_q;
  reg             tx_all_empty_flag;
  reg             tx_holding_empty_flag;
  reg             line_break_flag;
  reg             frame_flag;
  reg  [9:0]      rmem [0:RX_DEPTH-1];
  reg  [RX_AW-1:0] rrd_q;
  reg  [RX_AW-1:0] rwr_q;
  reg  [RX_AW:0]  rcnt_q;
  reg  [9:0]      hold_rx_q;
  reg             hold_rx_full_q;
  reg             head_new_q;
  wire            head_load;
  wire            fifo_mode;
  wire            acc;
  wire            wr_tx;
  wire            rd_stat;
  wire            rd_rx;
  wire            txd_w;
  wire            hold_empty;
  wire            shift_busy;
  wire            move_stb;
  wire            chr_stb;
  wire [7:0]      chr_data;
  wire            chr_frame;
  wire            chr_break;
  wire            rx_push;
  wire            rx_pop;
  wire [9:0]      rx_head;
  wire            rx_any;
  wire [7:0]      status_w;

  // Address match, shared by every decode below.
  function hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  assign fifo_mode = ctl_q[`CTL_FIFO_MODE];
  assign acc       = PSEL && PENABLE && PREADY;
  assign wr_tx     = acc && PWRITE && hit(PADDR, `OFS_TXDATA);
  assign rd_stat   = acc && !PWRITE && hit(PADDR, `OFS_STATUS);
  assign rd_rx     = acc && !PWRITE && hit(PADDR, `OFS_RXDATA);

  // Baud divider gives a 16x enable, then a bit enable for the transmitter.
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      div_q <= 16'h0000; os_tick_q <= 1'b0; tick16_q <= 4'h0; bit_tick_q <= 1'b0;
    end else begin
      os_tick_q  <= (div_q == 16'h0000);
      div_q      <= (div_q == 16'h0000) ? ctl_q[`CTL_DIV_LO+`CTL_DIV_W-1:`CTL_DIV_LO]
                                        : div_q - 16'h0001;
      bit_tick_q <= os_tick_q && (tick16_q == `OVERSAMPLE);
      if (os_tick_q) tick16_q <= tick16_q + 4'h1;
    end
  end

  tx_side #(.DEPTH(16), .AW(4)) u_tx (
    .clk        (MCLK),
    .rst_n      (RESETN),
    .fifo_mode  (fifo_mode),
    .wr_stb     (wr_tx),
    .wr_data    (PWDATA[7:0]),
    .bit_tick   (bit_tick_q),
    .txd        (txd_w),
    .hold_empty (hold_empty),
    .shift_busy (shift_busy),
    .move_stb   (move_stb)
  );

  rx_side u_rx (
    .clk       (MCLK),
    .rst_n     (RESETN),
    .os_tick   (os_tick_q),
    .parity_en (ctl_q[`CTL_PARITY_EN]),
    .rxd       (RXD),
    .chr_stb   (chr_stb),
    .chr_data  (chr_data),
    .chr_frame (chr_frame),
    .chr_break (chr_break)
  );

  // Transmit flags; the write cycle and the move cycle are decided here so a
  // write that collides with a move still leaves the flag clear.
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_holding_empty_flag <= 1'b1;
      tx_all_empty_flag     <= 1'b1;
      TX_IRQ                <= 1'b0;
      TXD                   <= 1'b1;
    end else begin
      TXD <= txd_w;
      if (wr_tx)
        tx_holding_empty_flag <= 1'b0;
      else if (move_stb)
        tx_holding_empty_flag <= 1'b1;
      else
        tx_holding_empty_flag <= hold_empty;
      // All-empty needs both stores idle, so it lags the shifter by a cycle.
      tx_all_empty_flag <= !wr_tx && hold_empty && !shift_busy && !move_stb;
      TX_IRQ <= ctl_q[`CTL_HOLD_IEN] && !wr_tx && (move_stb || tx_holding_empty_flag);
    end
  end

  // Receive store: FIFO in FIFO mode, else one holding word; overflow drops in FIFO mode, overwrites the holding word otherwise.
  assign rx_push = chr_stb && (fifo_mode ? (rcnt_q != RX_DEPTH) : 1'b1);
  assign rx_pop  = rd_rx && (fifo_mode ? (rcnt_q != {(RX_AW+1){1'b0}}) : hold_rx_full_q);
  assign rx_head = fifo_mode ? rmem[rrd_q] : hold_rx_q;
  assign rx_any  = fifo_mode ? (rcnt_q != {(RX_AW+1){1'b0}}) : hold_rx_full_q;
  // A new character reaches the head of the FIFO.
  assign head_load = fifo_mode &&
                     ((rx_pop && (rcnt_q > {{RX_AW{1'b0}}, 1'b1} || rx_push)) ||
                      (rx_push && rcnt_q == {(RX_AW+1){1'b0}}));

  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rrd_q <= {RX_AW{1'b0}}; rwr_q <= {RX_AW{1'b0}}; rcnt_q <= {(RX_AW+1){1'b0}};
      hold_rx_q <= 10'h000; hold_rx_full_q <= 1'b0; head_new_q <= 1'b0;
    end else begin
      head_new_q <= head_load;
      if (rx_push && fifo_mode) begin
        rmem[rwr_q] <= {chr_break, chr_frame, chr_data};
        rwr_q       <= rwr_q + 1'b1;
      end
      if (rx_pop && fifo_mode) rrd_q <= rrd_q + 1'b1;
      if (fifo_mode)
        rcnt_q <= rcnt_q + {{RX_AW{1'b0}}, rx_push} - {{RX_AW{1'b0}}, rx_pop};
      if (rx_push && !fifo_mode) begin
        hold_rx_q      <= {chr_break, chr_frame, chr_data};
        hold_rx_full_q <= 1'b1;
      end else if (rx_pop) begin
        hold_rx_full_q <= 1'b0;
      end
    end
  end

  // Break and frame flags follow the head character in FIFO mode; the status
  // read clears them, but a new arrival in that cycle wins.
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      line_break_flag <= 1'b0;
      frame_flag      <= 1'b0;
    end else begin
      if (fifo_mode) begin
        // Loaded once per head character, so a status read clears it for good.
        if (head_new_q) line_break_flag <= rx_head[9];
        else if (rd_stat || !rx_any) line_break_flag <= 1'b0;
        if (head_new_q) frame_flag <= rx_head[8];
        else if (rd_stat || !rx_any) frame_flag <= 1'b0;
      end else begin
        if (chr_stb && chr_break) line_break_flag <= 1'b1;
        else if (rd_stat) line_break_flag <= 1'b0;
        if (chr_stb && chr_frame) frame_flag <= 1'b1;
        else if (rd_stat) frame_flag <= 1'b0;
      end
    end
  end

  assign status_w = {1'b0, tx_all_empty_flag, tx_holding_empty_flag, line_break_flag,
                     frame_flag, 2'b00, rx_any};

  // APB slave: one wait state, read data registered; unmapped reads zero with error.
  always @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
      ctl_q   <= `CTL_RESET;
    end else begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PSLVERR <= 1'b0;
      if (PSEL && PENABLE && !PREADY) begin
        PRDATA <= 32'h00000000;
        if (hit(PADDR, `OFS_STATUS))       PRDATA <= {24'h000000, status_w};
        else if (hit(PADDR, `OFS_CONTROL)) PRDATA <= ctl_q;
        else if (hit(PADDR, `OFS_RXDATA))  PRDATA <= {24'h000000, rx_head[7:0]};
        else if (hit(PADDR, `OFS_TXSTATE))
          PRDATA <= {29'h00000000, move_stb, shift_busy, hold_empty};
        else if (!hit(PADDR, `OFS_TXDATA)) PSLVERR <= 1'b1;
      end
      // Writes take effect only at the edge where the transfer completes.
      if (acc && PWRITE && hit(PADDR, `OFS_CONTROL)) ctl_q <= PWDATA;
    end
  end
endmodule
`default_nettype wire

// >>> uart_line_status_checker.sv
// Purpose: Bus and flag assertions for the line status block.
// Assumes: Sees only top ports; the interrupt enable is shadowed from bus writes.
// Notes:   Bound into every instance of the top module.
`timescale 1ns/100ps
`default_nettype none
`include "lsr_defines.vh"
module uart_line_status_checker (
  input wire logic        MCLK,
  input wire logic        RESETN,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        TX_IRQ
);
  logic       done;
  logic       mapped;
  logic       st_rd;
  logic       ien_q;
  logic [7:0] wcnt_q;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  // A transfer completes at the edge where the slave answers.
  assign done   = PSEL && PENABLE && PREADY;
  assign st_rd  = done && !PWRITE && PADDR == `OFS_STATUS;
  assign mapped = PADDR == `OFS_TXDATA || PADDR == `OFS_CONTROL || PADDR == `OFS_RXDATA
               || PADDR == `OFS_TXSTATE || PADDR == `OFS_STATUS;
  // The write age saturates, so a long quiet spell never wraps back into the busy window.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ien_q  <= 1'b0;
      wcnt_q <= 8'hFF;
    end else begin
      if (done && PWRITE && PADDR == `OFS_CONTROL) ien_q <= PWDATA[`CTL_HOLD_IEN];
      if (done && PWRITE && PADDR == `OFS_TXDATA) wcnt_q <= 8'h00;
      else if (wcnt_q != 8'hFF) wcnt_q <= wcnt_q + 8'h01;
    end
  end
  ready_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("slave late in access phase");
  ready_pulse_a: assert property ($rose(PREADY) |=> !PREADY)
    else $error("ready held too long");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  unmapped_err_a: assert property (done && !mapped |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (done && mapped && !PWRITE |-> !PSLVERR)
    else $error("mapped read refused");
  empty_order_a: assert property (
    st_rd && PRDATA[`BIT_ALL_EMPTY] |-> PRDATA[`BIT_HOLD_EMPTY])
    else $error("all empty without holding empty");
  busy_after_a: assert property (
    st_rd && wcnt_q < 8'h64 |-> !PRDATA[`BIT_ALL_EMPTY])
    else $error("all empty while a character is held");
  irq_off_a: assert property (!ien_q && !$past(ien_q) |-> !TX_IRQ)
    else $error("interrupt while disabled");
endmodule
bind uart_line_status uart_line_status_checker i_chk (
  .MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TX_IRQ(TX_IRQ)
);
`default_nettype wire

// >>> rx_sender.sv
// Purpose: Remote serial transmitter driving the receive line.
// Assumes: One bit lasts BIT_CYC clocks, LSB first, line idles high.
// Notes:   Callers build whole bit strings, so bad stop bits and breaks are plain data.
`timescale 1ns/100ps
`default_nettype none
module rx_sender #(
  parameter int BIT_CYC = 16
) (
  input  wire logic clk,
  output var logic  line
);
  initial line = 1'b1;
  // Shifts n bits out, then marks two bit times so the receiver can rearm.
  task automatic send(input logic [31:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      line <= bits[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
    @(posedge clk);
    line <= 1'b1;
    repeat (2 * BIT_CYC) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Purpose: Self-checking bench for the line status block.
// Assumes: Divider 0, so one serial bit is 16 clocks.
// Notes:   Receive expectations come from a queue model of the receive FIFO.
`timescale 1ns/100ps
`default_nettype none
`include "lsr_defines.vh"
module tb;
  logic        mclk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  wire         rxd;
  logic        txd;
  logic        tx_irq;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  a;
  logic [7:0]  b;
  int          e;
  int          rx_q[$];
  int          bad_count;
  int          n_tests;
  uart_line_status i_uart_line_status (
    .MCLK(mclk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RXD(rxd), .TXD(txd), .TX_IRQ(tx_irq)
  );
  rx_sender #(.BIT_CYC(16)) i_rx_sender (.clk(mclk), .line(rxd));
  // Free-running 40 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Counts a comparison and reports a mismatch on the spot.
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_word({31'h0, got}, {31'h0, exp}, what);
  endtask
  // One bus transfer; the request stands until ready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk_bit(pready, 1'b1, "ready");
  endtask
  // Reads status until one bit reaches a level, with a bounded number of tries.
  task automatic poll(input int bi, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, `OFS_STATUS, 32'h0);
      n++;
    end while (rd[bi] !== v && n < 300);
    chk_bit(rd[bi], v, "poll");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence: reset, refusal, transmit flags, then receive flags.
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    bad_count = 0;
    n_tests = 0;
    void'($urandom(32'hCFDA9233));
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk_word(rd & 32'h79, 32'h60, "reset status");
    apb(1'b0, 12'h010, 32'h0);
    chk_bit(err, 1'b1, "unmapped error");
    chk_word(rd, 32'h0, "unmapped data");
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, `OFS_CONTROL, 32'h1 | (m << 1));
      repeat (3) @(posedge mclk);
      chk_bit(tx_irq, 1'b1, "irq idle");
      // The first character goes to the shifter, so the rest cannot move early.
      apb(1'b1, `OFS_TXDATA, $urandom & 32'hFF);
      poll(`BIT_HOLD_EMPTY, 1'b1);
      for (int i = 0; i < 1 + m; i++) apb(1'b1, `OFS_TXDATA, $urandom & 32'hFF);
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk_word(rd & 32'h60, 32'h0, "loaded");
      chk_bit(tx_irq, 1'b0, "irq loaded");
      poll(`BIT_HOLD_EMPTY, 1'b1);
      chk_bit(rd[`BIT_ALL_EMPTY], 1'b0, "shifter busy");
      poll(`BIT_ALL_EMPTY, 1'b1);
      chk_word(rd & 32'h79, 32'h60, "drained");
      chk_bit(tx_irq, 1'b1, "irq drained");
      chk_bit(txd, 1'b1, "line idle");
    end
    apb(1'b1, `OFS_CONTROL, 32'h2);
    repeat (3) @(posedge mclk);
    chk_bit(tx_irq, 1'b0, "irq masked");
    // Model entries: data, frame at bit 8, break at bit 9.
    a = $urandom;
    i_rx_sender.send({21'h0, 1'b1, a, 1'b0}, 10);
    rx_q.push_back(a);
    // A zero first byte with a low stop would look like the front of a break.
    a = $urandom | 32'h1;
    b = $urandom;
    i_rx_sender.send({12'h0, 1'b1, b, 1'b0, a, 1'b0}, 19);
    rx_q.push_back(a | 256);
    rx_q.push_back(b);
    i_rx_sender.send(32'h0, 30);
    rx_q.push_back(768);
    while (rx_q.size() > 0) begin
      e = rx_q.pop_front();
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk_word(rd & 32'h19, 32'h1 | (e[8] << 3) | (e[9] << 4), "rx flags");
      if (e[9]) begin
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk_bit(rd[`BIT_BREAK], 1'b0, "break cleared");
      end
      apb(1'b0, `OFS_RXDATA, 32'h0);
      chk_word(rd & 32'hFF, e & 32'hFF, "rx data");
    end
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk_bit(rd[`BIT_RX_READY], 1'b0, "one break char");
    give_verdict();
  end
  // Watchdog: the sequence needs well under ten thousand cycles.
  initial begin
    #(25 * 20000);
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
